// ### master_control_registers.sv
`timescale 1ns/1ps
// What this block does
// - Any device reset clears all register bits except the reset bit, which sets.
// - Global enable low blocks requests and acknowledges, chain still passes through.
// - Vector register reads include status exactly when global enable is 1.
// - Lower-chain disable forces chain enable output low, else normal chaining.
// - No-vector bit suppresses vector drive on acknowledge, in-service still sets.
// - Port A acknowledge gives base vector, or status-modified vector when its bit set.
// - Per-source status bits never change what software reads from vector registers.
// - Port B and the shared counter vector follow the same status-include scheme.
// - Multiplexed bus: justify 0 takes address bit 0 from bus bit 1, else bit 0.
// - Separate-address variant: justify bit unused and always reads as 1.
// - Writing 1 to the reset bit resets the device; hardware reset sets it too.
// - While reset bit is 1, other registers read 0, ignore writes; clears by writing 0.
// - Port B enable low blocks new pending, gates ready/wait, catchers, floats lines.
// - Counter 1 or 2 enable low holds that counter/timer initialized.
// - Bit 4 enables port C and counter 3; low idles handshakes, acknowledge input high.
// - Port link joins A and B into 16 bits using port A handshake registers.
// - Port A enable governs port A as port B enable governs port B.
// - Counter link field: independent, inverted gate, inverted trigger, inverted count.
module master_control_registers #(
  parameter int MUX_BUS = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Host bus: strobe1N is address strobe or read, strobe2N is data strobe or write
  input wire logic strobe1N,
  input wire logic strobe2N,
  input wire logic readNotWrite,
  input wire logic [7:0] busIn,
  input wire logic [5:0] regAddrIn,
  output logic [7:0] busOut,
  output logic busOe,
  // Register images for the rest of the device
  output master_control_pkg::mic_t intControl,
  output master_control_pkg::mcc_t configControl,
  output logic deviceReset,
  // Daisy chain and interrupt requests
  input wire logic chainEnableIn,
  input wire logic anyPending,
  input wire logic anyInService,
  input wire logic ackCycle,
  input wire master_control_pkg::int_source_t ackSource,
  output logic chainEnableOut,
  output logic intRequestN,
  output logic inServiceSet,
  // Vectors for the acknowledged source and for register reads
  input wire logic [7:0] baseVector,
  input wire logic [7:0] statusVector,
  output logic [7:0] vectorOut,
  output logic vectorOe,
  output logic vectorReadStatus,
  // Port and counter/timer gating
  input wire logic handshakeAckInN,
  output master_control_pkg::port_ctrl_t portaCtrl,
  output master_control_pkg::port_ctrl_t portbCtrl,
  output master_control_pkg::port_ctrl_t portcCtrl,
  output master_control_pkg::counter_ctrl_t counter1Ctrl,
  output master_control_pkg::counter_ctrl_t counter2Ctrl,
  output master_control_pkg::counter_ctrl_t counter3Ctrl,
  output logic handshakeIdle,
  output logic handshakeAckInGatedN,
  output logic portsLinked,
  // Counter/timer 2 input selection
  input wire logic counter1Out,
  input wire logic counter2ExtGate,
  input wire logic counter2ExtTrigger,
  input wire logic counter2ExtCount,
  output logic counter2Gate,
  output logic counter2Trigger,
  output logic counter2Count
);

  if (MUX_BUS < 0 || MUX_BUS > 1) begin : g_bad_variant
    $error("MUX_BUS must be 0 or 1");
  end

  master_control_pkg::mic_t micReg;
  master_control_pkg::mic_t micNext;
  master_control_pkg::mcc_t mccReg;
  master_control_pkg::mcc_t mccNext;
  logic [5:0] addrLatchReg;
  logic strobe1Reg;
  logic strobe2Reg;
  logic ackReg;

  // Bus phase decode.
  wire hwReset = !strobe1N && !strobe2N;
  wire s1Fall = strobe1Reg && !strobe1N;
  wire s2Fall = strobe2Reg && !strobe2N;
  wire [5:0] muxAddr = micReg.addressJustify ? busIn[5:0] : busIn[6:1];
  wire addrLoad = (MUX_BUS == 1) && s1Fall && strobe2N;
  wire [5:0] accessAddr = (MUX_BUS == 1) ? addrLatchReg : regAddrIn;
  wire writeStrobe = (MUX_BUS == 1) ? (s2Fall && !readNotWrite && strobe1N)
                                    : (s2Fall && strobe1N);
  wire readActive = (MUX_BUS == 1) ? (!strobe2N && readNotWrite && strobe1N)
                                   : (!strobe1N && strobe2N);
  wire selMic = accessAddr == master_control_pkg::MIC_ADDR;
  wire selMcc = accessAddr == master_control_pkg::MCC_ADDR;
  wire inReset = micReg.softReset;

  // The justify bit has no function without the multiplexed bus.
  wire justifyRead = (MUX_BUS == 1) ? micReg.addressJustify : 1'b1;
  wire [7:0] micRead = {micReg[7:2], justifyRead, micReg.softReset};
  // Anything other than the interrupt control register reads zero during reset.
  wire [7:0] readData = selMic ? micRead : ((selMcc && !inReset) ? mccReg : 8'h00);

  // Writing 1 to the reset bit restarts the device, so the other bits return to zero.
  wire micWrite = writeStrobe && selMic;
  wire mccWrite = writeStrobe && selMcc && !inReset;

  always_comb begin
    micNext = micReg;
    mccNext = mccReg;
    if (hwReset) begin
      micNext = master_control_pkg::MIC_RESET;
      mccNext = master_control_pkg::MCC_RESET;
    end else if (micWrite && busIn[0]) begin
      micNext = master_control_pkg::MIC_RESET;
      mccNext = master_control_pkg::MCC_RESET;
    end else if (micWrite) begin
      micNext = busIn;
    end else if (mccWrite) begin
      mccNext = busIn;
    end
    if (micNext.softReset) begin
      mccNext = master_control_pkg::MCC_RESET;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      micReg <= master_control_pkg::MIC_RESET;
      mccReg <= master_control_pkg::MCC_RESET;
    end else begin
      micReg <= micNext;
      mccReg <= mccNext;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addrLatchReg <= 6'h00;
      strobe1Reg <= 1'b1;
      strobe2Reg <= 1'b1;
      ackReg <= 1'b0;
    end else begin
      if (addrLoad) begin
        addrLatchReg <= muxAddr;
      end
      strobe1Reg <= strobe1N;
      strobe2Reg <= strobe2N;
      ackReg <= ackCycle;
    end
  end

  // Interrupt side. A disabled device keeps the chain intact but takes no part itself.
  wire intEnabled = micReg.globalIntEnable && !inReset;
  wire active = intEnabled && chainEnableIn;
  wire ackStart = ackCycle && !ackReg;
  wire ownChainBlock = intEnabled && (anyInService || (ackCycle && anyPending));
  wire chainOut = chainEnableIn && !micReg.lowerChainDisable && !ownChainBlock;
  wire reqOn = active && anyPending;
  wire respond = active && ackStart && anyPending;
  wire srcStatus = (ackSource == master_control_pkg::SRC_PORTA) ? micReg.portaVectorStatus :
                   (ackSource == master_control_pkg::SRC_PORTB) ? micReg.portbVectorStatus :
                   micReg.counterVectorStatus;
  wire [7:0] ackVector = srcStatus ? statusVector : baseVector;
  wire driveVector = active && ackCycle && anyPending && !micReg.noVectorOutput;

  // Unit gating. Enable bits are held in the register, so a disabled unit stays put.
  function automatic master_control_pkg::port_ctrl_t portGate(input logic en);
    portGate = '{pendingSetAllow: en, readyWaitAllow: en, catcherTransparent: !en, linesDrive: en};
  endfunction : portGate

  function automatic master_control_pkg::counter_ctrl_t counterGate(input logic en);
    counterGate = '{pendingSetAllow: en, holdInit: !en};
  endfunction : counterGate

  wire master_control_pkg::counter_link_t linkMode = master_control_pkg::counter_link_t'(mccReg.counterLink);
  wire ct1Inv = !counter1Out;
  wire gateSel = (linkMode == master_control_pkg::LINK_GATE) ? ct1Inv : counter2ExtGate;
  wire trigSel = (linkMode == master_control_pkg::LINK_TRIGGER) ? ct1Inv : counter2ExtTrigger;
  // Software must clear counter 2's external count enable; the pin is simply replaced here.
  wire countSel = (linkMode == master_control_pkg::LINK_COUNT) ? ct1Inv : counter2ExtCount;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busOut <= 8'h00;
      busOe <= 1'b0;
      intControl <= master_control_pkg::MIC_RESET;
      configControl <= master_control_pkg::MCC_RESET;
      deviceReset <= 1'b1;
      chainEnableOut <= 1'b0;
      intRequestN <= 1'b1;
      inServiceSet <= 1'b0;
      vectorOut <= 8'h00;
      vectorOe <= 1'b0;
      vectorReadStatus <= 1'b0;
    end else begin
      busOut <= readActive ? readData : 8'h00;
      busOe <= readActive;
      intControl <= micReg;
      configControl <= mccReg;
      deviceReset <= inReset;
      chainEnableOut <= chainOut;
      intRequestN <= !reqOn;
      inServiceSet <= respond;
      vectorOut <= driveVector ? ackVector : 8'h00;
      vectorOe <= driveVector;
      vectorReadStatus <= intEnabled;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      portaCtrl <= master_control_pkg::PORT_CTRL_RESET;
      portbCtrl <= master_control_pkg::PORT_CTRL_RESET;
      portcCtrl <= master_control_pkg::PORT_CTRL_RESET;
      counter1Ctrl <= master_control_pkg::COUNTER_CTRL_RESET;
      counter2Ctrl <= master_control_pkg::COUNTER_CTRL_RESET;
      counter3Ctrl <= master_control_pkg::COUNTER_CTRL_RESET;
      handshakeIdle <= 1'b1;
      handshakeAckInGatedN <= 1'b1;
      portsLinked <= 1'b0;
      counter2Gate <= 1'b0;
      counter2Trigger <= 1'b0;
      counter2Count <= 1'b0;
    end else begin
      portaCtrl <= portGate(mccReg.portaEnable);
      portbCtrl <= portGate(mccReg.portbEnable);
      portcCtrl <= portGate(mccReg.portcEnable);
      counter1Ctrl <= counterGate(mccReg.counter1Enable);
      counter2Ctrl <= counterGate(mccReg.counter2Enable);
      counter3Ctrl <= counterGate(mccReg.portcEnable);
      handshakeIdle <= !mccReg.portcEnable;
      handshakeAckInGatedN <= handshakeAckInN || !mccReg.portcEnable;
      // Link order is the host's duty; the bit is honoured whenever it is set.
      portsLinked <= mccReg.portLink;
      counter2Gate <= gateSel;
      counter2Trigger <= trigSel;
      counter2Count <= countSel;
    end
  end

endmodule : master_control_registers

// ### master_control_pkg.sv
package master_control_pkg;

  // Register addresses inside the six-bit register space.
  localparam logic [5:0] MIC_ADDR = 6'h00;
  localparam logic [5:0] MCC_ADDR = 6'h01;

  typedef struct packed {
    logic globalIntEnable;
    logic lowerChainDisable;
    logic noVectorOutput;
    logic portaVectorStatus;
    logic portbVectorStatus;
    logic counterVectorStatus;
    logic addressJustify;
    logic softReset;
  } mic_t;

  typedef struct packed {
    logic portbEnable;
    logic counter1Enable;
    logic counter2Enable;
    logic portcEnable;
    logic portLink;
    logic portaEnable;
    logic [1:0] counterLink;
  } mcc_t;

  localparam mic_t MIC_RESET = 8'h01;
  localparam mcc_t MCC_RESET = 8'h00;

  typedef enum logic [1:0] {
    LINK_INDEPENDENT = 2'b00,
    LINK_GATE = 2'b01,
    LINK_TRIGGER = 2'b10,
    LINK_COUNT = 2'b11
  } counter_link_t;

  typedef enum logic [1:0] {
    SRC_PORTA = 2'b00,
    SRC_PORTB = 2'b01,
    SRC_COUNTER = 2'b10
  } int_source_t;

  // Gating handed to one port's logic.
  typedef struct packed {
    logic pendingSetAllow;
    logic readyWaitAllow;
    logic catcherTransparent;
    logic linesDrive;
  } port_ctrl_t;

  // Gating handed to one counter/timer.
  typedef struct packed {
    logic pendingSetAllow;
    logic holdInit;
  } counter_ctrl_t;

  localparam port_ctrl_t PORT_CTRL_RESET = 4'h2;
  localparam counter_ctrl_t COUNTER_CTRL_RESET = 2'h1;

endpackage : master_control_pkg

// ### master_control_properties.sv
`timescale 1ns/1ps
module master_control_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Bus strobes and register images
  input wire logic strobe1N,
  input wire logic strobe2N,
  input wire master_control_pkg::mic_t intControl,
  input wire master_control_pkg::mcc_t configControl,
  // Interrupt side
  input wire logic chainEnableOut,
  input wire logic inServiceSet,
  input wire logic vectorOe,
  input wire logic vectorReadStatus,
  // Gating side
  input wire master_control_pkg::port_ctrl_t portbCtrl,
  input wire master_control_pkg::counter_ctrl_t counter1Ctrl,
  input wire logic handshakeAckInGatedN,
  input wire logic counter1Out,
  input wire logic counter2Count
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Two edges are allowed because the register loads on the first edge and its image intControl follows one edge later.
  hw_reset_a: assert property (!strobe1N && !strobe2N |-> ##[1:2] intControl == 8'h01)
    else $error("hardware reset not applied");
  reset_clear_a: assert property (intControl.softReset |-> configControl == 8'h00)
    else $error("configuration kept while reset bit set");
  // The register images and the gated outputs are registered from the same state, so they align.
  chain_block_a: assert property (intControl.lowerChainDisable |-> !chainEnableOut)
    else $error("chain output not forced low");
  disabled_ack_a: assert property (!intControl.globalIntEnable |-> !inServiceSet && !vectorOe)
    else $error("acknowledge answered while disabled");
  no_vec_a: assert property (intControl.noVectorOutput |-> !vectorOe)
    else $error("vector driven with no-vector set");
  read_status_a: assert property (vectorReadStatus == intControl.globalIntEnable)
    else $error("vector read status wrong");
  portb_gate_a: assert property (!configControl.portbEnable |-> portbCtrl == 4'h2)
    else $error("port B not gated");
  counter_hold_a: assert property (!configControl.counter1Enable |-> counter1Ctrl == 2'h1)
    else $error("counter 1 not held");
  ack_in_a: assert property (!configControl.portcEnable |-> handshakeAckInGatedN)
    else $error("acknowledge input not held high");
  count_link_a: assert property (configControl.counterLink == 2'b11 |-> counter2Count == !$past(counter1Out))
    else $error("counter 2 count input not linked");
  cover property (!strobe1N && !strobe2N);
  cover property (inServiceSet && !vectorOe);
  cover property (configControl.counterLink == 2'b11 && !counter1Out);
endmodule : master_control_properties
bind master_control_registers master_control_properties chk_u (.*);

// ### host_model.sv
`timescale 1ns/1ps
module host_model (
  // Clock and read data
  input wire logic mclk,
  input wire logic [7:0] busOut,
  // Strobes, address and write data
  output logic strobe1N,
  output logic strobe2N,
  output logic [5:0] regAddrIn,
  output logic [7:0] busIn
);
  initial begin
    strobe1N = 1'b1;
    strobe2N = 1'b1;
    regAddrIn = 6'h00;
    busIn = 8'h00;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge mclk);
    #1;
    regAddrIn = a;
    busIn = v;
    strobe2N = 1'b0;
    @(posedge mclk);
    #1;
    strobe2N = 1'b1;
    // A released bus must not keep showing the written byte.
    busIn = ~v;
    repeat (2) @(posedge mclk);
    #1;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge mclk);
    #1;
    regAddrIn = a;
    strobe1N = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    v = busOut;
    strobe1N = 1'b1;
  endtask : rd
  task automatic hwrst();
    @(posedge mclk);
    #1;
    strobe1N = 1'b0;
    strobe2N = 1'b0;
    @(posedge mclk);
    #1;
    strobe1N = 1'b1;
    strobe2N = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
  endtask : hwrst
endmodule : host_model

// ### master_control_registers_tb.sv
`timescale 1ns/1ps
module master_control_registers_tb;
  localparam logic [5:0] micAddr = master_control_pkg::MIC_ADDR;
  localparam logic [5:0] mccAddr = master_control_pkg::MCC_ADDR;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic strobe1N, strobe2N, busOe, deviceReset, chainEnableOut, intRequestN, inServiceSet;
  logic vectorOe, vectorReadStatus, handshakeIdle, handshakeAckInGatedN, portsLinked;
  logic counter2Gate, counter2Trigger, counter2Count, readNotWrite, chainEnableIn, anyPending;
  logic anyInService, ackCycle, handshakeAckInN, counter1Out;
  logic counter2ExtGate, counter2ExtTrigger, counter2ExtCount;
  logic [7:0] busIn, busOut, baseVector, statusVector, vectorOut, d;
  logic [5:0] regAddrIn;
  master_control_pkg::mic_t intControl;
  master_control_pkg::mcc_t configControl;
  master_control_pkg::int_source_t ackSource;
  master_control_pkg::port_ctrl_t portaCtrl, portbCtrl, portcCtrl;
  master_control_pkg::counter_ctrl_t counter1Ctrl, counter2Ctrl, counter3Ctrl;
  logic mxS1N = 1'b1;
  logic mxS2N = 1'b1;
  logic mxRnw = 1'b0;
  logic [7:0] mxBusIn = 8'h00;
  logic [7:0] mxBusOut;
  master_control_pkg::mcc_t mxConfigControl;
  int n_mismatch = 0;
  int num_checks = 0;
  master_control_registers #(.MUX_BUS(0)) dut_u (.*);
  master_control_registers #(.MUX_BUS(1)) mux_u (
    .mclk(mclk), .nrst(nrst), .strobe1N(mxS1N), .strobe2N(mxS2N), .readNotWrite(mxRnw),
    .busIn(mxBusIn), .regAddrIn(6'h00), .busOut(mxBusOut), .busOe(), .intControl(),
    .configControl(mxConfigControl), .deviceReset(), .chainEnableIn(chainEnableIn), .anyPending(anyPending),
    .anyInService(anyInService), .ackCycle(ackCycle), .ackSource(ackSource), .chainEnableOut(),
    .intRequestN(), .inServiceSet(), .baseVector(baseVector), .statusVector(statusVector), .vectorOut(),
    .vectorOe(), .vectorReadStatus(), .handshakeAckInN(handshakeAckInN), .portaCtrl(), .portbCtrl(),
    .portcCtrl(), .counter1Ctrl(), .counter2Ctrl(), .counter3Ctrl(), .handshakeIdle(),
    .handshakeAckInGatedN(), .portsLinked(), .counter1Out(counter1Out), .counter2ExtGate(counter2ExtGate),
    .counter2ExtTrigger(counter2ExtTrigger), .counter2ExtCount(counter2ExtCount), .counter2Gate(),
    .counter2Trigger(), .counter2Count()
  );
  host_model host_u (.*);
  always #2.5 mclk = ~mclk;
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic t_reset();
    chk("mic", 8'h01, intControl);
    chk("mcc", 8'h00, configControl);
    host_u.rd(micAddr, d);
    chk("mic read", 8'h03, d);
    chk("bus oe", 8'h01, {7'h00, busOe});
    host_u.wr(mccAddr, 8'hff);
    chk("mcc gated", 8'h00, configControl);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs();
    host_u.wr(micAddr, 8'h00);
    chk("reset bit", 8'h00, {7'h00, deviceReset});
    host_u.wr(mccAddr, 8'h5a);
    host_u.rd(mccAddr, d);
    chk("mcc read", 8'h5a, d);
    host_u.rd(6'h3f, d);
    chk("unmapped", 8'h00, d);
    host_u.wr(micAddr, 8'h01);
    host_u.rd(mccAddr, d);
    chk("soft reset", 8'h00, d);
    host_u.wr(micAddr, 8'h00);
    host_u.wr(mccAddr, 8'h5a);
    host_u.hwrst();
    chk("hw mic", 8'h01, intControl);
    chk("hw mcc", 8'h00, configControl);
    $display("test registers done");
  endtask : t_regs
  task automatic ack(input logic [7:0] m, input logic [1:0] s, input logic [7:0] eo, ei, ev);
    host_u.wr(micAddr, m);
    ackSource = master_control_pkg::int_source_t'(s);
    ackCycle = 1'b1;
    @(posedge mclk);
    #1;
    chk("vector oe", eo, {7'h00, vectorOe});
    chk("in service", ei, {7'h00, inServiceSet});
    chk("request", {7'h00, !ei[0]}, {7'h00, intRequestN});
    if (eo[0]) chk("vector", ev, vectorOut);
    chk("read status", {7'h00, m[7]}, {7'h00, vectorReadStatus});
    ackCycle = 1'b0;
    @(posedge mclk);
  endtask : ack
  task automatic t_ack();
    chainEnableIn = 1'b1;
    anyPending = 1'b1;
    baseVector = 8'h20;
    statusVector = 8'h2e;
    ack(8'h00, 2'h0, 8'h00, 8'h00, 8'h00);
    ack(8'h90, 2'h0, 8'h01, 8'h01, 8'h2e);
    ack(8'h90, 2'h1, 8'h01, 8'h01, 8'h20);
    ack(8'h88, 2'h1, 8'h01, 8'h01, 8'h2e);
    ack(8'h84, 2'h2, 8'h01, 8'h01, 8'h2e);
    ack(8'hb0, 2'h0, 8'h00, 8'h01, 8'h00);
    anyPending = 1'b0;
    host_u.wr(micAddr, 8'hc0);
    chk("chain blocked", 8'h00, {7'h00, chainEnableOut});
    host_u.wr(micAddr, 8'h00);
    chk("chain passed", 8'h01, {7'h00, chainEnableOut});
    $display("test acknowledge done");
  endtask : t_ack
  task automatic t_link();
    counter1Out = 1'b0;
    for (int i = 0; i < 4; i++) begin
      host_u.wr(mccAddr, 8'h08 | 8'(i));
      chk("link", (8'h08 >> i) & 8'h07, {5'h00, counter2Gate, counter2Trigger, counter2Count});
    end
    // Link codes are set before the units are enabled, as software must.
    host_u.wr(mccAddr, 8'hfb);
    chk("linked", 8'h01, {7'h00, portsLinked});
    chk("port A off", 8'h02, {4'h0, portaCtrl});
    chk("port B on", 8'h0d, {4'h0, portbCtrl});
    chk("counter 1 on", 8'h02, {6'h00, counter1Ctrl});
    chk("counter 2 on", 8'h02, {6'h00, counter2Ctrl});
    chk("counter 3 on", 8'h02, {6'h00, counter3Ctrl});
    chk("handshake run", 8'h00, {7'h00, handshakeIdle});
    counter1Out = 1'b1;
    handshakeAckInN = 1'b0;
    @(posedge mclk);
    #1;
    chk("count link", 8'h00, {7'h00, counter2Count});
    chk("ack in passed", 8'h00, {7'h00, handshakeAckInGatedN});
    host_u.wr(mccAddr, 8'h0b);
    chk("ack in held", 8'h01, {7'h00, handshakeAckInGatedN});
    chk("handshake idle", 8'h01, {7'h00, handshakeIdle});
    chk("port B off", 8'h02, {4'h0, portbCtrl});
    chk("counter 1 off", 8'h01, {6'h00, counter1Ctrl});
    handshakeAckInN = 1'b1;
    $display("test link done");
  endtask : t_link
  task automatic mx(input logic rnw, input logic [7:0] a, input logic [7:0] v, output logic [7:0] r);
    @(posedge mclk);
    #1;
    mxBusIn = a;
    mxS1N = 1'b0;
    @(posedge mclk);
    #1;
    mxS1N = 1'b1;
    mxBusIn = v;
    mxRnw = rnw;
    mxS2N = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    r = mxBusOut;
    mxS2N = 1'b1;
    mxRnw = 1'b0;
    mxBusIn = ~v;
    repeat (2) @(posedge mclk);
    #1;
  endtask : mx
  task automatic t_mux();
    mx(1'b0, 8'h00, 8'h00, d);
    mx(1'b0, 8'h02, 8'h33, d);
    chk("mux mcc", 8'h33, mxConfigControl);
    mx(1'b1, 8'h01, 8'h00, d);
    chk("mux shifted", 8'h00, d);
    mx(1'b0, 8'h00, 8'h02, d);
    mx(1'b1, 8'h01, 8'h00, d);
    chk("mux right", 8'h33, d);
    mx(1'b1, 8'h00, 8'h00, d);
    chk("mux mic", 8'h02, d);
    $display("test multiplexed done");
  endtask : t_mux
  initial begin
    readNotWrite = 1'b0;
    chainEnableIn = 1'b0;
    anyPending = 1'b0;
    anyInService = 1'b0;
    ackCycle = 1'b0;
    ackSource = master_control_pkg::SRC_PORTA;
    baseVector = 8'h00;
    statusVector = 8'h00;
    handshakeAckInN = 1'b1;
    counter1Out = 1'b0;
    counter2ExtGate = 1'b0;
    counter2ExtTrigger = 1'b0;
    counter2ExtCount = 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    nrst = 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    t_regs();
    t_ack();
    t_link();
    t_mux();
    summarize();
  end
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
endmodule : master_control_registers_tb
